// file: shared/irq_tick_map.svh
// constants of the interrupt request and periodic tick block
// Summary of operation
// RULE_01: a mode bit selects edge-only or edge-and-level detection of the external pin.
// RULE_02: the pin event flag sets when the pin moves from deasserted to asserted.
// RULE_03: in edge-and-level mode the flag stays set, uncleared, while the pin is asserted.
// RULE_04: each condition sets its own flag and is forwarded to the entry sequencer only when its local enable is 1.
// RULE_05: pending and unmasked, five register bytes stack in order, then the mask sets.
// RULE_06: after stacking, the top-priority pending vector is fetched and service starts there.
// RULE_07: the vector high byte is read at the first vector address and the low byte at the next.
// RULE_08: the tick control register has a read-only status flag and a write-only acknowledge bit.
// RULE_09: a three-bit period select picks one of seven tick intervals.
// RULE_10: a tick local enable masks the tick request when cleared; the code gates only the sequencer request with it, not irq_o.
// RULE_11: period select zero stops the tick clock so no ticks are produced.
// RULE_12: with background debug active in stop3 the internal tick clock is unavailable.
// RULE_13: the tick flag sets at each interval end; writing 1 to acknowledge clears it.
`ifndef IRQ_TICK_MAP_SVH
`define IRQ_TICK_MAP_SVH
`define REG_PIN_CTRL 4'h0
`define REG_TICK_CTRL 4'h1
`define REG_IRQ_STATUS 4'h2
`define REG_IRQ_MASK 4'h3
`define REG_CPU_CTRL 4'h4
`define REG_VECTOR 4'h5
`define REG_STACK 4'h6
`define PIN_MODE_BIT 0
`define PIN_ENABLE_BIT 1
`define PIN_FLAG_BIT 2
`define PIN_ACK_BIT 3
`define TICK_SEL_LSB 0
`define TICK_ENABLE_BIT 4
`define TICK_ACK_BIT 6
`define TICK_FLAG_BIT 7
`define CPU_MASK_BIT 0
`define CPU_DONE_BIT 1
`define VEC_PIN 16'hFFFA
`define VEC_TICK 16'hFFCC
`define TICK_BASE_US 8
`define TICK_BASE_CYC ((`TICK_BASE_US * 25) - 1)
`define STACK_DEPTH 5
`endif

// file: shared/irq_tick_pkg.sv
// types of the interrupt request and periodic tick block
package irq_tick_pkg;
  typedef enum logic [2:0] {
    cpu_run, cpu_stack, cpu_vec_hi, cpu_vec_lo, cpu_service
  } cpu_state_e;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;
  typedef struct packed {
    logic tick;
    logic pin;
  } src_bits_s;
endpackage : irq_tick_pkg

// file: rtl/tick_divider.sv
// periodic tick divider with period select and stop
`timescale 1ns/1ps
`default_nettype none
`include "irq_tick_map.svh"
module tick_divider
  import irq_tick_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [2:0] period_sel_i,
  input wire logic clk_block_i,
  output logic tick_o
);
  logic [7:0] base_cnt;
  logic [15:0] div_cnt;
  logic base_tick;
  logic running;

  // one-of-seven limit as a power of two of base periods
  function automatic logic [15:0] period_limit(input logic [2:0] sel);
    period_limit = (16'h0001 << (2 * sel)) - 16'h0001;
  endfunction : period_limit

  // RULE_11: zero stops clock
  // RULE_12: debug stop3 gate
  assign running = (period_sel_i != 3'h0) && !clk_block_i;
  assign base_tick = running && (base_cnt == 8'(`TICK_BASE_CYC));

  // base prescaler, held cleared while stopped
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || !running || base_tick) begin
      base_cnt <= 8'h00;
    end else begin
      base_cnt <= base_cnt + 8'h01;
    end
  end

  // RULE_09: seven selectable periods
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || !running) begin
      div_cnt <= 16'h0000;
      tick_o <= 1'b0;
    end else if (base_tick) begin
      tick_o <= (div_cnt >= period_limit(period_sel_i));
      div_cnt <= (div_cnt >= period_limit(period_sel_i)) ? 16'h0000 : div_cnt + 16'h0001;
    end else begin
      tick_o <= 1'b0;
    end
  end
endmodule : tick_divider
`default_nettype wire

// file: rtl/irq_tick_ctrl.sv
// external pin detector, tick source, request gating and cpu entry sequencer
`timescale 1ns/1ps
`default_nettype none
`include "irq_tick_map.svh"
module irq_tick_ctrl
  import irq_tick_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic ext_irq_n_i,
  input wire logic stop3_i,
  input wire logic debug_active_i,
  input wire logic insn_end_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic [15:0] pc_i,
  input wire logic [7:0] index_low_i,
  input wire logic [7:0] acc_i,
  input wire logic [7:0] ccr_i,
  output logic [7:0] stack_data_o,
  output logic stack_push_o,
  output logic [15:0] vec_addr_o,
  output logic vec_rd_o,
  input wire logic [7:0] vec_data_i,
  output logic [15:0] service_addr_o,
  output logic service_go_o,
  output logic irq_o
);
  reg_req_s req;
  logic [2:0] pin_sync;
  logic pin_level;
  logic pin_prev;
  logic pin_rise;
  logic pin_detect_level_mode;
  logic pin_enable;
  logic ext_pin_event_flag;
  logic [2:0] tick_period_select;
  logic tick_request_enable;
  logic tick_flag;
  logic tick_pulse;
  src_bits_s status;
  src_bits_s mask;
  src_bits_s pending;
  logic global_mask;
  cpu_state_e state;
  logic [2:0] stack_idx;
  logic [15:0] vec_base;
  logic [7:0] vec_hi;
  logic [7:0] stack_byte [`STACK_DEPTH];

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // -------------------------------------------------------------
  // external pin detector
  // -------------------------------------------------------------

  // pin comes from outside; act only when stages two and three agree
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      pin_sync <= 3'h0;
      pin_level <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      pin_sync <= {pin_sync[1:0], !ext_irq_n_i};
      if (pin_sync[1] == pin_sync[2]) begin
        pin_level <= pin_sync[2];
      end
      pin_prev <= pin_level;
    end
  end

  // RULE_02: deasserted to asserted
  assign pin_rise = pin_level && !pin_prev;

  // RULE_01: mode picks edge or level
  // RULE_03: level holds flag set
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ext_pin_event_flag <= 1'b0;
    end else if (pin_rise || (pin_detect_level_mode && pin_level)) begin
      ext_pin_event_flag <= 1'b1;
    end else if (req.wr && req.addr == `REG_PIN_CTRL && req.wdata[`PIN_ACK_BIT]) begin
      ext_pin_event_flag <= 1'b0;
    end
  end

  // -------------------------------------------------------------
  // periodic tick source
  // -------------------------------------------------------------

  // RULE_12: stop3 with debug kills clock
  tick_divider tick_divider_inst (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .period_sel_i(tick_period_select),
    .clk_block_i(stop3_i && debug_active_i),
    .tick_o(tick_pulse)
  );

  // RULE_13: set at interval end, ack clears
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      tick_flag <= 1'b0;
    end else if (tick_pulse) begin
      tick_flag <= 1'b1;
    end else if (req.wr && req.addr == `REG_TICK_CTRL && req.wdata[`TICK_ACK_BIT]) begin
      tick_flag <= 1'b0;
    end
  end

  // -------------------------------------------------------------
  // control registers
  // -------------------------------------------------------------

  // software controls; flags are not writable here
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      pin_detect_level_mode <= 1'b0;
      pin_enable <= 1'b0;
      tick_period_select <= 3'h0;
      tick_request_enable <= 1'b0;
      mask <= '0;
    end else if (req.wr) begin
      if (req.addr == `REG_PIN_CTRL) begin
        pin_detect_level_mode <= req.wdata[`PIN_MODE_BIT];
        pin_enable <= req.wdata[`PIN_ENABLE_BIT];
      end else if (req.addr == `REG_TICK_CTRL) begin
        tick_period_select <= req.wdata[`TICK_SEL_LSB +: 3];
        tick_request_enable <= req.wdata[`TICK_ENABLE_BIT];
      end else if (req.addr == `REG_IRQ_MASK) begin
        mask <= req.wdata[1:0];
      end
    end
  end

  // RULE_04: flag gated by local enable
  // RULE_10: tick enable masks request
  assign pending.pin = ext_pin_event_flag && pin_enable;
  assign pending.tick = tick_flag && tick_request_enable;

  // sticky status; the set wins over the clear by read
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      status <= '0;
    end else begin
      status.pin <= pin_rise || (status.pin && !(req.rd && req.addr == `REG_IRQ_STATUS));
      status.tick <= tick_pulse || (status.tick && !(req.rd && req.addr == `REG_IRQ_STATUS));
    end
  end

  assign irq_o = |(status & mask);

  // RULE_08: flag read only, ack write only
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rdata_o <= 8'h00;
    end else if (!req.rd) begin
      rdata_o <= 8'h00;
    end else if (req.addr == `REG_PIN_CTRL) begin
      rdata_o <= {5'h00, ext_pin_event_flag, pin_enable, pin_detect_level_mode};
    end else if (req.addr == `REG_TICK_CTRL) begin
      rdata_o <= {tick_flag, 2'b00, tick_request_enable, 1'b0, tick_period_select};
    end else if (req.addr == `REG_IRQ_STATUS) begin
      rdata_o <= {6'h00, status};
    end else if (req.addr == `REG_IRQ_MASK) begin
      rdata_o <= {6'h00, mask};
    end else if (req.addr == `REG_CPU_CTRL) begin
      rdata_o <= {6'h00, state == cpu_service, global_mask};
    end else if (req.addr == `REG_VECTOR) begin
      rdata_o <= service_addr_o[7:0];
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // -------------------------------------------------------------
  // cpu entry sequencer
  // -------------------------------------------------------------

  // RULE_05: stacking order
  assign stack_byte[0] = pc_i[7:0];
  assign stack_byte[1] = pc_i[15:8];
  assign stack_byte[2] = index_low_i;
  assign stack_byte[3] = acc_i;
  assign stack_byte[4] = ccr_i;

  // RULE_06: pin outranks tick
  assign vec_base = pending.pin ? `VEC_PIN : `VEC_TICK;

  // stack; vector fetch and mask set start with the fifth stacked byte, then hand over
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state <= cpu_run;
      stack_idx <= 3'h0;
      global_mask <= 1'b1;
      stack_push_o <= 1'b0;
      stack_data_o <= 8'h00;
      vec_rd_o <= 1'b0;
      vec_addr_o <= 16'h0000;
      vec_hi <= 8'h00;
      service_addr_o <= 16'h0000;
      service_go_o <= 1'b0;
    end else begin
      stack_push_o <= 1'b0;
      vec_rd_o <= 1'b0;
      service_go_o <= 1'b0;
      if (req.wr && req.addr == `REG_CPU_CTRL) begin
        global_mask <= req.wdata[`CPU_MASK_BIT];
      end
      case (state)
        cpu_run: begin
          // RULE_05: wait for instruction end
          if ((pending.pin || pending.tick) && !global_mask && insn_end_i) begin
            state <= cpu_stack;
            stack_idx <= 3'h0;
          end
        end
        cpu_stack: begin
          stack_push_o <= 1'b1;
          stack_data_o <= stack_byte[stack_idx];
          if (stack_idx == 3'(`STACK_DEPTH - 1)) begin
            global_mask <= 1'b1;
            state <= cpu_vec_hi;
            vec_addr_o <= vec_base;
            vec_rd_o <= 1'b1;
          end else begin
            stack_idx <= stack_idx + 3'h1;
          end
        end
        cpu_vec_hi: begin
          // RULE_07: high byte first
          vec_hi <= vec_data_i;
          vec_addr_o <= vec_addr_o + 16'h0001;
          vec_rd_o <= 1'b1;
          state <= cpu_vec_lo;
        end
        cpu_vec_lo: begin
          // RULE_07: low byte next
          service_addr_o <= {vec_hi, vec_data_i};
          service_go_o <= 1'b1;
          state <= cpu_service;
        end
        cpu_service: begin
          if (req.wr && req.addr == `REG_CPU_CTRL && req.wdata[`CPU_DONE_BIT]) begin
            state <= cpu_run;
          end
        end
        default: begin
          state <= cpu_run;
        end
      endcase
    end
  end
endmodule : irq_tick_ctrl
`default_nettype wire

// file: tb/irq_tick_checker.sv
// concurrent checks on the interrupt controller ports
`timescale 1ns/1ps
`default_nettype none
`include "irq_tick_map.svh"
module irq_tick_checker (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic stack_push_o,
  input wire logic [15:0] vec_addr_o,
  input wire logic vec_rd_o,
  input wire logic [7:0] vec_data_i,
  input wire logic [15:0] service_addr_o,
  input wire logic service_go_o,
  input wire logic irq_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_stack5; $rose(stack_push_o) |-> stack_push_o [*5] ##1 !stack_push_o; endproperty
  a_stack5: assert property (p_stack5) else $error("stacking not five bytes");
  property p_vecat; $rose(stack_push_o) |-> ##4 $rose(vec_rd_o); endproperty
  a_vecat: assert property (p_vecat) else $error("vector fetch misplaced");
  property p_vecadr;
    $rose(vec_rd_o) |-> vec_addr_o == `VEC_PIN || vec_addr_o == `VEC_TICK;
  endproperty
  a_vecadr: assert property (p_vecadr) else $error("bad vector address");
  property p_veclo; $rose(vec_rd_o) |=> vec_rd_o && vec_addr_o == $past(vec_addr_o) + 16'h0001;
  endproperty
  a_veclo: assert property (p_veclo) else $error("low byte not next address");
  property p_go; $rose(vec_rd_o) |-> ##2 service_go_o ##1 !service_go_o; endproperty
  a_go: assert property (p_go) else $error("service start misplaced");
  property p_svc;
    service_go_o |-> service_addr_o == {$past(vec_data_i, 2), $past(vec_data_i)};
  endproperty
  a_svc: assert property (p_svc) else $error("service address wrong");
  property p_ack; rd_i && addr_i == `REG_TICK_CTRL |=> !rdata_o[`TICK_ACK_BIT]; endproperty
  a_ack: assert property (p_ack) else $error("acknowledge bit readable");
  property p_mask; wr_i && addr_i == `REG_IRQ_MASK && wdata_i[1:0] == 2'h0 |=> !irq_o;
  endproperty
  a_mask: assert property (p_mask) else $error("masked request forwarded");
endmodule : irq_tick_checker
bind irq_tick_ctrl irq_tick_checker irq_tick_checker_inst (.ref_clk_i(ref_clk_i),
  .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .stack_push_o(stack_push_o), .vec_addr_o(vec_addr_o),
  .vec_rd_o(vec_rd_o), .vec_data_i(vec_data_i), .service_addr_o(service_addr_o),
  .service_go_o(service_go_o), .irq_o(irq_o));
`default_nettype wire

// file: tb/cpu_core_model.sv
// processor side: instruction boundaries and vector memory
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic slow_i,
  input wire logic vec_rd_i,
  input wire logic [15:0] vec_addr_i,
  output logic insn_end_o,
  output logic [7:0] vec_data_o
);
  logic [1:0] cnt;
  logic [7:0] idle_bus;
  // boundaries every cycle, or every fourth when slow
  always_ff @(posedge ref_clk_i) begin
    cnt <= sys_rst_i ? 2'h0 : cnt + 2'h1;
    insn_end_o <= !sys_rst_i && (!slow_i || cnt == 2'h3);
  end
  // unread bus shows the inverse of its last value, so a late sample is caught
  always_ff @(posedge ref_clk_i) begin
    idle_bus <= sys_rst_i ? 8'h00 : ~vec_data_o;
  end
  // high byte first; memory answers in the cycle of the read strobe
  always_comb begin
    vec_data_o = idle_bus;
    if (vec_rd_i) begin
      if (vec_addr_i == 16'hFFFA) vec_data_o = 8'hA5;
      else if (vec_addr_i == 16'hFFFB) vec_data_o = 8'hC3;
      else if (vec_addr_i == 16'hFFCC) vec_data_o = 8'h5A;
      else if (vec_addr_i == 16'hFFCD) vec_data_o = 8'h3C;
      else vec_data_o = vec_addr_i[7:0];
    end
  end
endmodule : cpu_core_model
`default_nettype wire

// file: tb/irq_and_periodic_interrupt_logic_bench.sv
// self-checking bench of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module irq_and_periodic_interrupt_logic_bench;
  logic clk, rst, ext_n, stop3, dbg, slow, wr, rd, push, vrd, go, irq, iend;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, sdata, vdata, xl, acc, condition_code_register, r;
  logic [15:0] pc, vaddr, saddr;
  integer seed = 32'h6a58ba37;
  int num_errors = 0;
  int n_checks = 0;
  int i;
  logic [7:0] q[$];
  irq_tick_ctrl irq_tick_ctrl_inst (.ref_clk_i(clk), .sys_rst_i(rst), .ext_irq_n_i(ext_n),
    .stop3_i(stop3), .debug_active_i(dbg), .insn_end_i(iend), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .pc_i(pc), .index_low_i(xl), .acc_i(acc),
    .ccr_i(condition_code_register), .stack_data_o(sdata), .stack_push_o(push), .vec_addr_o(vaddr),
    .vec_rd_o(vrd), .vec_data_i(vdata), .service_addr_o(saddr), .service_go_o(go), .irq_o(irq));
  cpu_core_model cpu_core_model_inst (.ref_clk_i(clk), .sys_rst_i(rst), .slow_i(slow),
    .vec_rd_i(vrd), .vec_addr_i(vaddr), .insn_end_o(iend), .vec_data_o(vdata));
  // clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // stacked bytes, taken at the edge closing each push cycle
  always @(posedge clk) if (push === 1'b1) q.push_back(sdata);
  task finish_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task rreg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 r = rdata;
  endtask : rreg
  // vector contents of the core model, high byte at the first address
  function automatic logic [15:0] exp_service(input logic pin);
    exp_service = pin ? 16'hA5C3 : 16'h5A3C;
  endfunction : exp_service
  // waits for the service start, then checks stack order and vector
  task entry(input logic [15:0] sa);
    for (i = 0; i < 4000 && go !== 1'b1; i++) @(posedge clk) #1;
    chk("stack count", 16'h0005, 16'(q.size()));
    chk("stack bytes", {pc[7:0], pc[15:8]}, {q[0], q[1]});
    chk("stack regs", {xl, acc}, {q[2], q[3]});
    chk("stack ccr", {8'h00, condition_code_register}, {8'h00, q[4]});
    chk("service go", 16'h0001, {15'h0, go});
    chk("service addr", sa, saddr);
    q.delete();
    @(posedge clk);
    {pc, xl, acc} <= 32'($random(seed));
    {condition_code_register, slow} <= 9'($random(seed));
  endtask : entry
  task pin_edge;
    @(posedge clk) ext_n <= 1'b1;
    repeat (8) @(posedge clk);
    ext_n <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : pin_edge
  initial begin
    {rst, ext_n, stop3, dbg, slow, wr, rd, addr, wdata} = {2'h3, 17'h0};
    {pc, xl, acc, condition_code_register} = 40'h12_3456_789A;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rreg(4'h4);
    chk("global mask", 16'h0001, {8'h00, r});
    rreg(4'h2);
    chk("status", 16'h0000, {8'h00, r});
    wreg(4'h3, 8'h03);
    wreg(4'h0, 8'h02);
    pin_edge();
    rreg(4'h0);
    chk("pin flag", 16'h0001, {15'h0, r[2]});
    wreg(4'h0, 8'h0A);
    rreg(4'h0);
    chk("edge ack", 16'h0000, {15'h0, r[2]});
    wreg(4'h0, 8'h0B);
    rreg(4'h0);
    chk("level hold", 16'h0001, {15'h0, r[2]});
    wreg(4'h0, 8'h0B);
    rreg(4'h0);
    chk("level no clear", 16'h0001, {15'h0, r[2]});
    @(posedge clk) ext_n <= 1'b1;
    repeat (8) @(posedge clk);
    wreg(4'h0, 8'h0B);
    rreg(4'h0);
    chk("level ack", 16'h0000, {15'h0, r[2]});
    wreg(4'h0, 8'h02);
    rreg(4'h2);
    pin_edge();
    wreg(4'h4, 8'h00);
    entry(exp_service(1'b1));
    wreg(4'h0, 8'h0A);
    rreg(4'h2);
    wreg(4'h4, 8'h03);
    wreg(4'h3, 8'h00);
    pin_edge();
    #1 chk("irq masked", 16'h0000, {15'h0, irq});
    wreg(4'h3, 8'h01);
    #1 chk("irq raised", 16'h0001, {15'h0, irq});
    for (int s = 1; s < 8; s++) begin
      wreg(4'h1, 8'(s));
      rreg(4'h1);
      chk("period sel", 16'(s), {13'h0, r[2:0]});
    end
    wreg(4'h1, 8'h50);
    repeat (3000) @(posedge clk);
    rreg(4'h1);
    chk("tick off", 16'h0000, {15'h0, r[7]});
    @(posedge clk) {stop3, dbg} <= 2'h3;
    wreg(4'h1, 8'h51);
    repeat (3000) @(posedge clk);
    rreg(4'h1);
    chk("tick stop3", 16'h0000, {15'h0, r[7]});
    @(posedge clk) {stop3, dbg} <= 2'h0;
    // four base periods of 200 cycles come before the first tick
    for (i = 0; i < 600 && r[7] !== 1'b1; i++) rreg(4'h1);
    chk("tick set", 16'h0001, {15'h0, r[7]});
    wreg(4'h1, 8'h51);
    rreg(4'h1);
    chk("tick ack", 16'h0000, {14'h0, r[7:6]});
    rreg(4'h2);
    // pin flag cleared and pin request disabled, so only the tick can enter
    wreg(4'h0, 8'h08);
    wreg(4'h3, 8'h02);
    wreg(4'h4, 8'h00);
    entry(exp_service(1'b0));
    wreg(4'h1, 8'h51);
    rreg(4'h2);
    wreg(4'h3, 8'h03);
    wreg(4'h0, 8'h02);
    pin_edge();
    repeat (1000) @(posedge clk);
    wreg(4'h4, 8'h02);
    entry(exp_service(1'b1));
    finish_test();
  end
  // watchdog
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    finish_test();
  end
endmodule : irq_and_periodic_interrupt_logic_bench
`default_nettype wire
